/* src/hms_sequencer.sv */
// Homing method sequencer: dictionary objects, search control, speed ramp
module hms_sequencer
  import hms_pkg::*;
#(
  parameter int unsigned RAMP_TICK_CYC = hms_pkg::RAMP_TICK_CYC_DEF
) (
  // Clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_rst,
  // Object dictionary access from the fieldbus process data
  input  wire logic                      i_od_wr,
  input  wire logic                      i_od_rd,
  input  wire logic [31:0]               i_od_addr,
  input  wire logic [31:0]               i_od_wdata,
  output logic      [31:0]               o_od_rdata,
  output logic                           o_od_ack,
  output logic                           o_od_err,
  // Discrete inputs from the machine, asynchronous
  input  wire logic                      i_origin_switch,
  input  wire logic                      i_negative_travel_limit,
  input  wire logic                      i_positive_travel_limit,
  input  wire logic                      i_index,
  // Encoder position, same clock
  input  wire logic [31:0]               i_position,
  // Motion command and results
  output logic      [hms_pkg::SPD_W-1:0] o_speed_cmd,
  output logic                           o_dir_neg,
  output logic                           o_homing_active,
  output logic      [31:0]               o_origin_pos,
  output logic                           o_origin_valid,
  output logic      [15:0]               o_status_word
);

  import hms_pkg::*;

  localparam logic [31:0] TICK_LAST = 32'(RAMP_TICK_CYC - 1);

  hms_state_s q;
  hms_state_s d;

  logic [IN_COUNT-1:0] in_lvl;
  logic [IN_COUNT-1:0] in_rise;
  logic [IN_COUNT-1:0] in_fall;
  logic [IN_COUNT-1:0] pins;

  // Pins are active high; the synchroniser returns levels and edges
  assign pins[IN_ORG] = i_origin_switch;
  assign pins[IN_NEG] = i_negative_travel_limit;
  assign pins[IN_POS] = i_positive_travel_limit;
  assign pins[IN_IDX] = i_index;

  hms_input_sync #(
    .WIDTH (IN_COUNT)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_pins  (pins),
    .o_level (in_lvl),
    .o_rise  (in_rise),
    .o_fall  (in_fall)
  );

  // Clamp a speed object into the usable range
  function automatic logic [SPD_W-1:0] clamp_speed(input logic [31:0] v);
    if (v > 32'(SPEED_MAX)) begin
      return SPEED_MAX;
    end
    return v[SPD_W-1:0];
  endfunction

  // Step size per ramp tick; zero is raised so motion can still finish
  function automatic logic [SPD_W-1:0] accel_step(input logic [31:0] v);
    if (v > 32'(ACCEL_MAX)) begin
      return ACCEL_MAX;
    end
    if (v[SPD_W-1:0] < ACCEL_MIN) begin
      return ACCEL_MIN;
    end
    return v[SPD_W-1:0];
  endfunction

  // Combinational next state
  always_comb begin
    logic             run;
    logic             run_start;
    logic             fault_rise;
    logic             abort;
    logic             tick_hit;
    logic             lim_ahead;
    logic             sw_edge;
    logic             trig_edge;
    logic             start_neg;
    logic             halt;
    logic [SPD_W-1:0] fast;
    logic [SPD_W-1:0] slow;
    logic [SPD_W-1:0] step;
    logic [SPD_W-1:0] goal;
    hms_method_s      dm;

    d          = q;
    d.ack      = 1'b0;
    d.od_err   = 1'b0;
    fast       = clamp_speed(q.regs.fast);
    slow       = clamp_speed(q.regs.slow);
    step       = accel_step(q.regs.accel);
    halt       = q.regs.control[CW_HALT_BIT];
    run        = (q.regs.control == CW_HOMING_RUN);
    run_start  = run && !q.prev_run;
    fault_rise = q.regs.control[CW_FAULT_BIT] && !q.prev_fault;
    abort      = !run || (q.regs.opmode != MODE_HOMING)
                 || q.regs.control[CW_FAULT_BIT];
    d.prev_run   = run;
    d.prev_fault = q.regs.control[CW_FAULT_BIT];
    lim_ahead  = q.dir_neg ? in_rise[IN_NEG] : in_rise[IN_POS];
    sw_edge    = in_rise[IN_ORG] || in_fall[IN_ORG];
    trig_edge  = q.meth.trig_rise ? in_rise[IN_ORG] : in_fall[IN_ORG];
    dm         = hms_decode_method(q.regs.method);
    start_neg  = 1'b0;
    tick_hit   = (q.tick == TICK_LAST);
    goal       = halt ? '0 : q.tgt;

    // Dictionary writes land one cycle before the sequencer sees them
    if (i_od_wr) begin
      d.ack = 1'b1;
      case (i_od_addr)
        OD_CONTROL: d.regs.control = i_od_wdata[15:0];
        OD_OPMODE:  d.regs.opmode  = i_od_wdata[7:0];
        OD_METHOD:  d.regs.method  = i_od_wdata[7:0];
        OD_FAST:    d.regs.fast    = i_od_wdata;
        OD_SLOW:    d.regs.slow    = i_od_wdata;
        OD_ACCEL:   d.regs.accel   = i_od_wdata;
        default:    d.od_err       = 1'b1;
      endcase
    end else if (i_od_rd) begin
      d.ack   = 1'b1;
      d.rdata = '0;
      case (i_od_addr)
        OD_CONTROL: d.rdata = {16'h0000, q.regs.control};
        OD_STATUS:  d.rdata = {16'h0000, o_status_word};
        OD_OPMODE:  d.rdata = {24'h000000, q.regs.opmode};
        OD_METHOD:  d.rdata = {24'h000000, q.regs.method};
        OD_FAST:    d.rdata = q.regs.fast;
        OD_SLOW:    d.rdata = q.regs.slow;
        OD_ACCEL:   d.rdata = q.regs.accel;
        default:    d.od_err = 1'b1;
      endcase
    end

    // One alarm clear per rising edge of the fault bit; a new error
    // raised later in this process in the same cycle still wins
    if (fault_rise) begin
      d.err = 1'b0;
    end

    // Sequencer phases
    case (q.phase)
      PH_IDLE: begin
        d.tgt = '0;
        // Only a fresh run request in homing mode starts a search
        if (run_start && !abort) begin
          d.meth         = dm;
          d.done         = 1'b0;
          d.err          = 1'b0;
          d.origin_valid = 1'b0;
          case (dm.start)
            START_NEG:    start_neg = 1'b1;
            START_POS:    start_neg = 1'b0;
            START_SW_POS: start_neg = in_lvl[IN_ORG];
            START_SW_NEG: start_neg = !in_lvl[IN_ORG];
            default:      start_neg = 1'b0;
          endcase
          if (dm.valid) begin
            d.active  = 1'b1;
            d.dir_neg = start_neg;
            d.phase   = PH_SEARCH;
            d.tgt     = fast;
            // Already sitting on the limit: back off it slowly
            if (dm.limit_based
                && (start_neg ? in_lvl[IN_NEG] : in_lvl[IN_POS])) begin
              d.dir_neg = !start_neg;
              d.phase   = PH_LEAVE;
              d.tgt     = slow;
            end
          end
        end
      end

      PH_SEARCH: begin
        if (q.meth.limit_based) begin
          // Deceleration point is the limit ahead: slow and reverse
          if (lim_ahead) begin
            d.dir_neg = !q.dir_neg;
            d.tgt     = slow;
            d.phase   = PH_LEAVE;
          end
        end else if ((q.dir_neg == q.meth.trig_neg) && trig_edge) begin
          // Defined edge in the defined direction: slow to the index
          d.tgt   = slow;
          d.phase = PH_INDEX;
        end else if ((q.dir_neg != q.meth.trig_neg) && sw_edge
                     && (in_lvl[IN_ORG] == !q.meth.trig_rise)) begin
          // Wrong way to meet the edge: turn round at low speed
          d.dir_neg = !q.dir_neg;
          d.tgt     = slow;
        end else if (lim_ahead) begin
          if (q.meth.turn_at_lim) begin
            d.dir_neg = !q.dir_neg;
            d.tgt     = slow;
          end else begin
            // These methods never search back past a limit
            d.err   = 1'b1;
            d.phase = PH_STOP;
          end
        end
      end

      PH_LEAVE: begin
        // Limit behind us released: the next index is the origin
        if (q.dir_neg ? in_fall[IN_POS] : in_fall[IN_NEG]) begin
          d.phase = PH_INDEX;
        end else if (lim_ahead) begin
          d.err   = 1'b1;
          d.phase = PH_STOP;
        end
      end

      PH_INDEX: begin
        // First index pulse at low speed fixes the origin
        if (in_rise[IN_IDX]) begin
          d.origin       = i_position;
          d.origin_valid = 1'b1;
          d.done         = 1'b1;
          d.phase        = PH_STOP;
        end else if (lim_ahead) begin
          d.err   = 1'b1;
          d.phase = PH_STOP;
        end
      end

      PH_STOP: begin
        // Wait for the ramp to reach standstill before going idle
        d.tgt = '0;
        if (q.spd == '0) begin
          d.phase  = PH_IDLE;
          d.active = 1'b0;
        end
      end

      default: begin
        d.phase  = PH_IDLE;
        d.active = 1'b0;
      end
    endcase

    // Losing the run value or the mode stops the search, no origin unless the index rises in that same cycle
    if (abort && (q.phase != PH_IDLE) && (q.phase != PH_STOP)) begin
      d.phase = PH_STOP;
    end
    if (d.phase == PH_STOP) begin
      d.tgt = '0;
    end

    // Ramp tick counter; steps are spaced so acceleration is bounded
    d.tick   = tick_hit ? '0 : q.tick + 32'h00000001;

    // Speed ramp: reversals pass through zero at the same rate
    if (tick_hit) begin
      if (q.act_neg != q.dir_neg) begin
        if (q.spd <= step) begin
          d.spd     = '0;
          d.act_neg = q.dir_neg;
        end else begin
          d.spd = q.spd - step;
        end
      end else if (q.spd < goal) begin
        d.spd = ((goal - q.spd) <= step) ? goal : q.spd + step;
      end else if (q.spd > goal) begin
        d.spd = ((q.spd - goal) <= step) ? goal : q.spd - step;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q              <= '0;
      q.phase        <= PH_IDLE;
      q.regs.control <= RST_CONTROL;
      q.regs.opmode  <= RST_OPMODE;
      q.regs.method  <= RST_METHOD;
      q.regs.fast    <= RST_FAST;
      q.regs.slow    <= RST_SLOW;
      q.regs.accel   <= RST_ACCEL;
    end else begin
      q <= d;
    end
  end

  // Outputs come from the state register
  assign o_od_rdata      = q.rdata;
  assign o_od_ack        = q.ack;
  assign o_od_err        = q.od_err;
  assign o_speed_cmd     = q.spd;
  assign o_dir_neg       = q.act_neg;
  assign o_homing_active = q.active;
  assign o_origin_pos    = q.origin;
  assign o_origin_valid  = q.origin_valid;

  // Only the homing bits are owned here; other status bits read zero
  always_comb begin
    o_status_word              = 16'h0000;
    o_status_word[SW_DONE_BIT] = q.done;
    o_status_word[SW_ERR_BIT]  = q.err;
  end

endmodule // hms_sequencer

/* src/hms_pkg.sv */
// Shared constants, types and method decoding for the homing sequencer
package hms_pkg;

  // Object dictionary addresses: index, subindex and size as one word
  localparam logic [31:0] OD_CONTROL = 32'h60400010;
  localparam logic [31:0] OD_STATUS  = 32'h60410010;
  localparam logic [31:0] OD_OPMODE  = 32'h60600008;
  localparam logic [31:0] OD_METHOD  = 32'h60980008;
  localparam logic [31:0] OD_FAST    = 32'h60990120;
  localparam logic [31:0] OD_SLOW    = 32'h60990220;
  localparam logic [31:0] OD_ACCEL   = 32'h609a0020;

  // Reset values of the dictionary objects
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [7:0]  RST_OPMODE  = 8'h00;
  localparam logic [7:0]  RST_METHOD  = 8'h00;
  localparam logic [31:0] RST_FAST    = 32'h0000c350;
  localparam logic [31:0] RST_SLOW    = 32'h00002710;
  localparam logic [31:0] RST_ACCEL   = 32'h000003e8;

  // Limits on speed (rpm) and on acceleration per ramp tick
  localparam int          SPD_W     = 16;
  localparam logic [15:0] SPEED_MAX = 16'h0bb8;
  localparam logic [15:0] ACCEL_MAX = 16'h03e8;
  localparam logic [15:0] ACCEL_MIN = 16'h0001;

  // Control word values and bits, operating mode, status bits
  localparam logic [15:0] CW_HOMING_RUN = 16'h001f;
  localparam int          CW_FAULT_BIT  = 7;
  localparam int          CW_HALT_BIT   = 8;
  localparam logic [7:0]  MODE_HOMING   = 8'h06;
  localparam int          SW_DONE_BIT   = 12;
  localparam int          SW_ERR_BIT    = 13;

  // Ramp tick: one acceleration step per millisecond
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam int unsigned RAMP_PERIOD_NS    = 1000000;
  localparam int unsigned RAMP_TICK_CYC_DEF = RAMP_PERIOD_NS / CLK_PERIOD_NS;

  // Positions of the discrete inputs in the synchroniser vector
  localparam int IN_ORG   = 0;
  localparam int IN_NEG   = 1;
  localparam int IN_POS   = 2;
  localparam int IN_IDX   = 3;
  localparam int IN_COUNT = 4;

  // How a method picks its start direction
  typedef enum logic [1:0] {
    START_NEG, START_POS, START_SW_POS, START_SW_NEG
  } hms_start_e;

  // Per-method search description
  typedef struct packed {
    logic       valid;       // Method runs a search at all
    logic       limit_based; // Deceleration point is a travel limit
    hms_start_e start;
    logic       trig_neg;    // Trigger edge is taken moving negative
    logic       trig_rise;   // Trigger edge is inactive to active
    logic       turn_at_lim; // Reverse rather than fail at a limit
  } hms_method_s;

  typedef enum logic [2:0] {
    PH_IDLE, PH_SEARCH, PH_LEAVE, PH_INDEX, PH_STOP
  } hms_phase_e;

  // Writable dictionary objects
  typedef struct packed {
    logic [15:0] control;
    logic [7:0]  opmode;
    logic [7:0]  method;
    logic [31:0] fast;
    logic [31:0] slow;
    logic [31:0] accel;
  } hms_regs_s;

  // Whole state of the sequencer
  typedef struct packed {
    hms_regs_s        regs;
    hms_phase_e       phase;
    hms_method_s      meth;
    logic             prev_run;
    logic             prev_fault;
    logic             dir_neg;   // Commanded direction
    logic             act_neg;   // Direction of the ramped output
    logic [SPD_W-1:0] tgt;
    logic [SPD_W-1:0] spd;
    logic [31:0]      tick;
    logic             done;
    logic             err;
    logic [31:0]      origin;
    logic             origin_valid;
    logic             active;
    logic [31:0]      rdata;
    logic             ack;
    logic             od_err;
  } hms_state_s;

  // Method number to search description; 0, 15 and above do nothing
  function automatic hms_method_s hms_decode_method(input logic [7:0] m);
    hms_method_s r;
    r = '0;
    r.valid = 1'b1;
    r.turn_at_lim = 1'b1;
    case (m)
      8'h01: begin r.limit_based = 1'b1; r.start = START_NEG;
                   r.trig_neg = 1'b1; r.trig_rise = 1'b1; end
      8'h02: begin r.limit_based = 1'b1; r.start = START_POS;
                   r.trig_rise = 1'b1; end
      8'h03: begin r.start = START_SW_POS; r.trig_neg = 1'b1;
                   r.turn_at_lim = 1'b0; end
      8'h04: begin r.start = START_SW_POS; r.trig_rise = 1'b1;
                   r.turn_at_lim = 1'b0; end
      8'h05: begin r.start = START_SW_NEG; r.turn_at_lim = 1'b0; end
      8'h06: begin r.start = START_SW_NEG; r.trig_neg = 1'b1;
                   r.turn_at_lim = 1'b0; end
      8'h07: begin r.start = START_SW_POS; r.trig_neg = 1'b1; end
      8'h08: begin r.start = START_SW_POS; r.trig_rise = 1'b1; end
      8'h09: begin r.start = START_POS; r.trig_neg = 1'b1;
                   r.trig_rise = 1'b1; end
      8'h0a: r.start = START_POS;
      8'h0b: r.start = START_SW_NEG;
      8'h0c: begin r.start = START_SW_NEG; r.trig_neg = 1'b1;
                   r.trig_rise = 1'b1; end
      8'h0d: begin r.start = START_NEG; r.trig_rise = 1'b1; end
      8'h0e: begin r.start = START_NEG; r.trig_neg = 1'b1; end
      default: r = '0;
    endcase
    return r;
  endfunction

endpackage

/* src/hms_input_sync.sv */
// Two-flop synchroniser with edge detection for the discrete inputs
module hms_input_sync #(
  parameter int WIDTH = 4
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  // Raw pins and conditioned outputs
  input  wire logic [WIDTH-1:0] i_pins,
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_fall
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
  } hms_sync_s;

  hms_sync_s q;
  hms_sync_s d;

  // Stage one feeds only stage two; edges compare stages two and three
  always_comb begin
    d    = q;
    d.s1 = i_pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Both directions of change are reported, one cycle each
  assign o_level = q.s2;
  assign o_rise  = q.s2 & ~q.s3;
  assign o_fall  = ~q.s2 & q.s3;

endmodule // hms_input_sync

/* bench/hms_seq_monitor.sv */
// Port-level assertions for the homing sequencer
module hms_seq_monitor
  import hms_pkg::*;
(
  // Clock and reset
  input wire logic             i_clk,
  input wire logic             i_rst,
  // Watched ports
  input wire logic             i_od_wr,
  input wire logic             i_od_rd,
  input wire logic             o_od_ack,
  input wire logic             i_index,
  input wire logic [SPD_W-1:0] o_speed_cmd,
  input wire logic             o_dir_neg,
  input wire logic             o_homing_active,
  input wire logic [31:0]      o_origin_pos,
  input wire logic             o_origin_valid,
  input wire logic [15:0]      o_status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // One clock domain, reset silences every check
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);

  speed_cap_a: assert property (o_speed_cmd <= SPEED_MAX)
    else $error("speed command above limit");
  ramp_step_a: assert property ((o_speed_cmd >= $past(o_speed_cmd)) ?
      (o_speed_cmd - $past(o_speed_cmd) <= ACCEL_MAX) :
      ($past(o_speed_cmd) - o_speed_cmd <= ACCEL_MAX))
    else $error("speed step larger than acceleration limit");
  // A reversal must pass through standstill, never jump across it
  reverse_at_rest_a: assert property ($changed(o_dir_neg) |->
      $past(o_speed_cmd) == 16'h0000 || o_speed_cmd == 16'h0000)
    else $error("direction changed while moving");
  idle_still_a: assert property (!o_homing_active |->
      o_speed_cmd == 16'h0000)
    else $error("speed commanded while not homing");
  status_clean_a: assert property ((o_status_word & 16'hcfff) == 16'h0000)
    else $error("status bits outside done and error set");
  done_origin_a: assert property (o_status_word[12] |-> o_origin_valid)
    else $error("done reported without an origin");
  origin_hold_a: assert property (o_origin_valid && $past(o_origin_valid)
      |-> $stable(o_origin_pos))
    else $error("origin moved after latching");
  index_latch_a: assert property ($rose(o_origin_valid) |->
      $past(i_index, 3))
    else $error("origin latched without index pulse");
  ack_answer_a: assert property ((i_od_wr || i_od_rd) |=> o_od_ack)
    else $error("dictionary request not answered");
  ack_cause_a: assert property (o_od_ack |-> $past(i_od_wr || i_od_rd))
    else $error("dictionary answer without request");
endmodule // hms_seq_monitor

bind hms_sequencer hms_seq_monitor u_mon (
  .i_clk           (i_clk),
  .i_rst           (i_rst),
  .i_od_wr         (i_od_wr),
  .i_od_rd         (i_od_rd),
  .o_od_ack        (o_od_ack),
  .i_index         (i_index),
  .o_speed_cmd     (o_speed_cmd),
  .o_dir_neg       (o_dir_neg),
  .o_homing_active (o_homing_active),
  .o_origin_pos    (o_origin_pos),
  .o_origin_valid  (o_origin_valid),
  .o_status_word   (o_status_word)
);

/* bench/hms_host_model.sv */
// Host controller model driving the object dictionary bus
module hms_host_model (
  // Clock
  input  wire logic        i_clk,
  // Dictionary bus towards the drive
  output logic             o_od_wr,
  output logic             o_od_rd,
  output logic [31:0]      o_od_addr,
  output logic [31:0]      o_od_wdata,
  input  wire logic [31:0] i_od_rdata,
  input  wire logic        i_od_ack,
  input  wire logic        i_od_err
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idle at time zero
  initial begin
    o_od_wr = 1'b0;
    o_od_rd = 1'b0;
    o_od_addr = 32'h0;
    o_od_wdata = 32'h0;
  end

  // One access; the strobe is a one-cycle pulse, answer one edge later
  task automatic od_access(input logic wr, input logic [31:0] addr,
                           input logic [31:0] data,
                           output logic [31:0] rd, output logic er);
    int n;
    @(negedge i_clk);
    o_od_wr = wr;
    o_od_rd = !wr;
    o_od_addr = addr;
    o_od_wdata = data;
    @(negedge i_clk);
    o_od_wr = 1'b0;
    o_od_rd = 1'b0;
    // Idle lines carry junk so a stale value is never trusted
    o_od_addr = ~addr;
    o_od_wdata = ~data;
    n = 0;
    while (i_od_ack !== 1'b1 && n < 4) begin
      @(negedge i_clk);
      n++;
    end
    rd = i_od_rdata;
    er = (i_od_ack === 1'b1) ? i_od_err : 1'b1;
  endtask

  // Control word ladder; 31 stays written for the whole run
  task automatic start_homing(output logic er);
    logic [31:0] ladder [4];
    logic [31:0] rd;
    logic        e;
    ladder = '{32'h00000006, 32'h00000007, 32'h0000000f, 32'h0000001f};
    er = 1'b0;
    foreach (ladder[k]) begin
      od_access(1'b1, hms_pkg::OD_CONTROL, ladder[k], rd, e);
      er = er | e;
    end
  endtask
endmodule // hms_host_model

/* bench/hms_sequencer_bench.sv */
// Self-checking bench for the homing sequencer
module hms_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import hms_pkg::*;

  // Clock, reset and machine pins
  logic             i_clk = 1'b0;
  logic             i_rst = 1'b1;
  logic             org_sw = 1'b0;
  logic             neg_lim = 1'b0;
  logic             pos_lim = 1'b0;
  logic             idx = 1'b0;
  logic [31:0]      pos = 32'h0;
  // Bus and results
  logic             od_wr, od_rd, od_ack, od_err;
  logic [31:0]      od_addr, od_wdata, od_rdata, org_pos, rd;
  logic [SPD_W-1:0] speed;
  logic             dir_neg, active, org_valid, er;
  logic [15:0]      status;
  int               mismatches = 0;
  int               checks_done = 0;
  // Reset table and start direction per method, bit m set = negative
  localparam logic [31:0] ADDRS [7] = '{OD_CONTROL, OD_OPMODE, OD_METHOD,
    OD_FAST, OD_SLOW, OD_ACCEL, OD_STATUS};
  localparam logic [31:0] RSTS [7] = '{32'(RST_CONTROL), 32'(RST_OPMODE),
    32'(RST_METHOD), RST_FAST, RST_SLOW, RST_ACCEL, 32'h0};
  localparam logic [15:0] NEG_SW [2] = '{16'h7862, 16'h619a};

  always #10 i_clk = ~i_clk;

  hms_host_model u_host (.i_clk(i_clk), .o_od_wr(od_wr), .o_od_rd(od_rd),
    .o_od_addr(od_addr), .o_od_wdata(od_wdata), .i_od_rdata(od_rdata),
    .i_od_ack(od_ack), .i_od_err(od_err));

  hms_sequencer #(.RAMP_TICK_CYC(4)) u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_od_wr(od_wr), .i_od_rd(od_rd), .i_od_addr(od_addr),
    .i_od_wdata(od_wdata), .o_od_rdata(od_rdata), .o_od_ack(od_ack),
    .o_od_err(od_err), .i_origin_switch(org_sw),
    .i_negative_travel_limit(neg_lim), .i_positive_travel_limit(pos_lim),
    .i_index(idx), .i_position(pos), .o_speed_cmd(speed),
    .o_dir_neg(dir_neg), .o_homing_active(active), .o_origin_pos(org_pos),
    .o_origin_valid(org_valid), .o_status_word(status));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    u_host.od_access(1'b1, a, d, rd, er);
    check(32'(er), 32'h0);
  endtask

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    u_host.od_access(1'b0, a, 32'h0, rd, er);
    check(rd, exp);
  endtask

  // Bounded wait: 0 speed, 1 direction, 2 active, 3 moving
  task automatic wait_sig(input int sel, input logic [31:0] v);
    logic [31:0] cur;
    for (int n = 0; n < 300; n++) begin
      cur = (sel == 0) ? 32'(speed) : (sel == 1) ? 32'(dir_neg) :
            (sel == 2) ? 32'(active) : 32'(speed != 16'h0);
      if (cur === v)
        break;
      @(negedge i_clk);
    end
    check(cur, v);
  endtask

  task automatic begin_run(input logic [7:0] mode, input logic [7:0] m);
    repeat (4) @(negedge i_clk);
    wr(OD_OPMODE, 32'(mode));
    wr(OD_METHOD, 32'(m));
    u_host.start_homing(er);
    check(32'(er), 32'h0);
  endtask

  // Abort leaves the run value so the next start sees a fresh edge
  task automatic end_run(input string name);
    wr(OD_CONTROL, 32'h0);
    wait_sig(2, 32'h0);
    $display("test %s done, mismatches %0d", name, mismatches);
  endtask

  task automatic index_pulse(input logic [31:0] p);
    pos = p;
    idx = 1'b1;
    repeat (8) @(negedge i_clk);
    idx = 1'b0;
    check(32'(org_valid), 32'h1);
    check(org_pos, p);
  endtask

  // Hang guard reckoned well above the expected run time
  initial begin
    #1000000;
    mismatches++;
    stop_test();
  end

  initial begin
    repeat (5) @(negedge i_clk);
    i_rst = 1'b0;
    foreach (ADDRS[k]) rd_chk(ADDRS[k], RSTS[k]);
    u_host.od_access(1'b0, 32'h60420010, 32'h0, rd, er);
    check(32'(er), 32'h1);
    wr(OD_FAST, 32'h1388);
    wr(OD_SLOW, 32'hc8);
    wr(OD_ACCEL, 32'h1f4);
    rd_chk(OD_FAST, 32'h1388);
    rd_chk(OD_ACCEL, 32'h1f4);
    // Start direction of every method against the switch level
    for (int s = 0; s < 2; s++) begin
      for (int m = 1; m < 15; m++) begin
        org_sw = s[0];
        begin_run(8'h06, 8'(m));
        wait_sig(3, 32'h1);
        check(32'(speed), 32'h1f4);
        check(32'(dir_neg), 32'(NEG_SW[s][m]));
        end_run("start direction");
      end
    end
    // Methods 1 and 2: limit ahead, reverse slow, index
    for (int k = 0; k < 2; k++) begin
      org_sw = 1'b0;
      begin_run(8'h06, 8'(k + 1));
      wait_sig(0, 32'hbb8);
      neg_lim = (k == 0);
      pos_lim = (k == 1);
      wait_sig(1, 32'(k));
      wait_sig(0, 32'hc8);
      neg_lim = 1'b0;
      pos_lim = 1'b0;
      repeat (4) @(negedge i_clk);
      index_pulse(32'h100 + 32'(k));
      wait_sig(2, 32'h0);
      end_run("limit methods");
    end
    // Method 4: rising switch moving positive, then done
    begin_run(8'h06, 8'h04);
    wait_sig(0, 32'hbb8);
    org_sw = 1'b1;
    wait_sig(0, 32'hc8);
    check(32'(dir_neg), 32'h0);
    index_pulse(32'h1234);
    rd_chk(OD_STATUS, 32'h1000);
    end_run("switch rise");
    // Method 3 started on the switch: falling switch moving negative
    begin_run(8'h06, 8'h03);
    wait_sig(3, 32'h1);
    org_sw = 1'b0;
    wait_sig(0, 32'hc8);
    check(32'(dir_neg), 32'h1);
    index_pulse(32'h55aa);
    end_run("switch fall");
    // Method 3 meeting the limit ahead fails; fault reset clears it
    begin_run(8'h06, 8'h03);
    wait_sig(3, 32'h1);
    pos_lim = 1'b1;
    wait_sig(2, 32'h0);
    rd_chk(OD_STATUS, 32'h2000);
    pos_lim = 1'b0;
    wr(OD_CONTROL, 32'h0);
    wr(OD_CONTROL, 32'h80);
    rd_chk(OD_STATUS, 32'h0);
    end_run("fault reset");
    // Wrong mode and reserved method stay still
    begin_run(8'h03, 8'h04);
    repeat (20) @(negedge i_clk);
    check(32'(active), 32'h0);
    begin_run(8'h06, 8'h0f);
    repeat (20) @(negedge i_clk);
    check(32'(active), 32'h0);
    rd_chk(OD_STATUS, 32'h0);
    end_run("no motion");
    stop_test();
  end
endmodule // hms_sequencer_bench
